// ==== rtl/ilsm_edge_counter.sv ====
/*
 * One input's edge counter: synchronises an external frame clock,
 * finds its rising edges and counts them over a window.
 * Assumes the frame clock is far slower than ref_clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ilsm_regs.svh"

module ilsm_edge_counter #(
    parameter int W = 16
) (
    input  wire logic         ref_clk_i,   // Block clock.
    input  wire logic         arst_n_i,    // Async reset, active low.
    input  wire logic         fclk_i,      // External frame clock pin.
    input  wire logic         clear_i,     // Restart the count.
    output logic              edge_o,      // Rising edge seen, one cycle.
    output logic [W-1:0]      count_o      // Edges since last clear.
);
    logic [2:0]   sync_r, sync_nxt;
    logic [W-1:0] cnt_r,  cnt_nxt;

    always_comb begin
        sync_nxt = {sync_r[1:0], fclk_i};
        cnt_nxt  = cnt_r;
        if (clear_i) begin
            cnt_nxt = {W{1'b0}};
        end
        // An edge in the clearing cycle is added by the reader to the window that
        // closes there, so it must not open the next window as well.
        if ((sync_r[2:1] == 2'b01) && !clear_i) begin
            cnt_nxt = cnt_r + W'(1);
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_r <= 3'h0;
            cnt_r  <= {W{1'b0}};
        end else begin
            sync_r <= sync_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    assign edge_o  = (sync_r[2:1] == 2'b01);
    assign count_o = cnt_r;
endmodule // ilsm_edge_counter

`default_nettype wire

// ==== rtl/ilsm_monitor.sv ====
/*
 * Input lock and sync monitor: per-input status, indicators, working
 * clock selection, three-sample pass-through delay and playback safety
 * buffer depth.
 * Assumes receivers report lock as pins and deliver frame clocks as pins.
 */
//
// Behaviour
// - Locked but unsynchronised input flashes its indicator.
// - Compare every locked input clock to working clock; flash any mismatch.
// - All synchronous inputs hold indicators steadily lit.
// - Report each input as no lock, lock or sync.
// - Follow-external mode takes working clock from chosen input.
// - Digital pass-through adds three sample periods of delay.
// - Playback side adds a fixed 64-sample buffer; record none.
`timescale 1ns/100ps
`default_nettype none
`include "ilsm_regs.svh"

module ilsm_monitor
    import ilsm_pkg::*;
#(
    parameter int N          = 3,
    parameter int SELW       = 2,
    parameter int FLASH_CYC  = `ILSM_FLASH_CYC
) (
    input  wire logic               ref_clk_i,                  // 250 MHz clock.
    input  wire logic               arst_n_i,                   // Async reset, active low.
    input  wire logic [N-1:0]       rx_lock_i,                  // Receiver lock pins.
    input  wire logic [N-1:0]       rx_fclk_i,                  // Recovered frame clocks.
    input  wire logic               int_fclk_i,                 // Internal frame clock.
    input  wire logic               follow_external_clock_mode_i, // Follow input clock.
    input  wire logic [SELW-1:0]    follow_sel_i,               // Input to follow.
    input  wire logic [15:0]        play_buf_i,                 // Selected buffer size.
    input  wire ilsm_pkg::ilsm_sample_s pass_in_i,              // Received sample.
    output ilsm_pkg::ilsm_sample_s  pass_out_o,                 // Delayed sample.
    output logic                    work_tick_o,                // Working frame pulse.
    output logic [N-1:0]            input_sync_indicator_o,     // Indicator drive.
    output logic [2*N-1:0]          status_o,                   // Two bits per input.
    output logic [15:0]             play_depth_o,               // Playback buffer depth.
    output logic [15:0]             rec_depth_o                 // Record buffer depth.
);
    logic [N-1:0]       lk_s1_r, lk_s2_r;
    logic [N-1:0]       lk_s1_nxt, lk_s2_nxt;
    logic [N-1:0]       in_edge;
    logic [N-1:0][15:0] in_cnt;
    logic               int_edge;
    logic               win_clr;
    logic [15:0]        win_r, win_nxt;
    logic [N-1:0]       sync_r, sync_nxt;
    logic [31:0]        fl_r, fl_nxt;
    logic               ph_r, ph_nxt;
    ilsm_sample_s       dly_r [`ILSM_PASS_DELAY];
    ilsm_sample_s       dly_nxt [`ILSM_PASS_DELAY];
    logic [15:0]        play_r, play_nxt;
    logic [15:0]        rec_r, rec_nxt;
    logic [N-1:0]       ind_r, ind_nxt;
    logic [2*N-1:0]     st_r, st_nxt;

    // ************************************************************
    //  Input edge counters
    // ************************************************************
    for (genvar g = 0; g < N; g++) begin : g_in
        ilsm_edge_counter #(.W(16)) u_cnt (
            .ref_clk_i (ref_clk_i),
            .arst_n_i  (arst_n_i),
            .fclk_i    (rx_fclk_i[g]),
            .clear_i   (win_clr),
            .edge_o    (in_edge[g]),
            .count_o   (in_cnt[g])
        );
    end

    ilsm_edge_counter #(.W(16)) u_int (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .fclk_i    (int_fclk_i),
        .clear_i   (1'b0),
        .edge_o    (int_edge),
        .count_o   ()
    );

    // ************************************************************
    //  Working clock and comparison window
    // ************************************************************
    always_comb begin
        // The lock pin is the receiver PLL's own verdict, so drift it tracks stays locked.
        work_tick_o = int_edge;
        if (follow_external_clock_mode_i && (int'(follow_sel_i) < N)) begin
            work_tick_o = in_edge[follow_sel_i] & lk_s2_r[follow_sel_i];
        end
        win_clr = work_tick_o && (win_r == `ILSM_WINDOW_FRAMES - 16'h0001);
        win_nxt = work_tick_o ? (win_clr ? 16'h0000 : win_r + 16'h0001) : win_r;
        sync_nxt = sync_r;
        for (int i = 0; i < N; i++) begin
            if (!lk_s2_r[i]) begin
                sync_nxt[i] = 1'b0;
            end else if (win_clr) begin
                // The counter has not yet seen an edge landing this same cycle,
                // so each input's own edge from this cycle is added back for fairness.
                sync_nxt[i] = ((in_cnt[i] + 16'(in_edge[i])) ==
                               `ILSM_WINDOW_FRAMES);
            end
        end
    end

    // ************************************************************
    //  Indicators and status
    // ************************************************************
    always_comb begin
        fl_nxt = fl_r + 32'h0000_0001;
        ph_nxt = ph_r;
        if (fl_r >= 32'(FLASH_CYC - 1)) begin
            fl_nxt = 32'h0000_0000;
            ph_nxt = ~ph_r;
        end
        for (int i = 0; i < N; i++) begin
            if (!lk_s2_r[i]) begin
                ind_nxt[i]       = 1'b0;
                st_nxt[2*i +: 2] = `ILSM_ST_NOLOCK;
            end else if (sync_r[i]) begin
                ind_nxt[i]       = 1'b1;
                st_nxt[2*i +: 2] = `ILSM_ST_SYNC;
            end else begin
                ind_nxt[i]       = ph_r;
                st_nxt[2*i +: 2] = `ILSM_ST_LOCK;
            end
        end
    end

    // ************************************************************
    //  Pass-through delay and buffer depths
    // ************************************************************
    always_comb begin
        for (int k = 0; k < `ILSM_PASS_DELAY; k++) begin
            dly_nxt[k] = dly_r[k];
        end
        if (work_tick_o) begin
            dly_nxt[0] = pass_in_i;
            for (int k = 1; k < `ILSM_PASS_DELAY; k++) begin
                dly_nxt[k] = dly_r[k-1];
            end
        end
        play_nxt = play_buf_i + `ILSM_SAFETY_SAMPLES;
        // The record path is only registered; it never sees the safety margin.
        rec_nxt  = play_buf_i;
    end

    // ************************************************************
    //  Lock synchroniser
    // ************************************************************
    // Lock pins change on the receivers' own time, so two stages come first.
    always_comb begin
        lk_s1_nxt = rx_lock_i;
        lk_s2_nxt = lk_s1_r;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lk_s1_r <= '0;
            lk_s2_r <= '0;
        end else begin
            lk_s1_r <= lk_s1_nxt;
            lk_s2_r <= lk_s2_nxt;
        end
    end

    // ************************************************************
    //  State registers
    // ************************************************************
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            win_r  <= 16'h0000;
            sync_r <= '0;
        end else begin
            win_r  <= win_nxt;
            sync_r <= sync_nxt;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fl_r <= 32'h0000_0000;
            ph_r <= 1'b0;
        end else begin
            fl_r <= fl_nxt;
            ph_r <= ph_nxt;
        end
    end

    // Status and indicators leave through flip-flops so the pins never glitch.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ind_r <= '0;
            st_r  <= '0;
        end else begin
            ind_r <= ind_nxt;
            st_r  <= st_nxt;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int k = 0; k < `ILSM_PASS_DELAY; k++) begin
                dly_r[k] <= '0;
            end
        end else begin
            for (int k = 0; k < `ILSM_PASS_DELAY; k++) begin
                dly_r[k] <= dly_nxt[k];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            play_r <= 16'h0000;
            rec_r  <= 16'h0000;
        end else begin
            play_r <= play_nxt;
            rec_r  <= rec_nxt;
        end
    end

    assign pass_out_o             = dly_r[`ILSM_PASS_DELAY-1];
    assign input_sync_indicator_o = ind_r;
    assign status_o               = st_r;
    assign play_depth_o           = play_r;
    assign rec_depth_o            = rec_r;
endmodule // ilsm_monitor

`default_nettype wire

// ==== rtl/ilsm_pkg.sv ====
/*
 * Types shared by the input lock and sync monitor.
 * Assumes the constants header is available beside it.
 */
package ilsm_pkg;

    typedef enum logic [1:0] {
        ILSM_NOLOCK = 2'h0,
        ILSM_LOCK   = 2'h1,
        ILSM_SYNC   = 2'h2
    } ilsm_status_e;

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } ilsm_sample_s;

    typedef struct packed {
        logic        lock;
        logic [15:0] count;
    } ilsm_rate_s;

endpackage

// ==== rtl/ilsm_regs.svh ====
/*
 * Timing and layout constants for the input lock and sync monitor.
 * Assumes inclusion by bare name from the rtl folder.
 */
`ifndef ILSM_REGS_SVH
`define ILSM_REGS_SVH

// Input clock status encoding.
`define ILSM_ST_NOLOCK      2'h0
`define ILSM_ST_LOCK        2'h1
`define ILSM_ST_SYNC        2'h2

// Pass-through delay in sample periods and playback safety buffer in samples.
`define ILSM_PASS_DELAY     3
`define ILSM_SAFETY_SAMPLES 16'h0040

// Working-clock frames per comparison window.
`define ILSM_WINDOW_FRAMES  16'h0040

// Flash half period in ref clock cycles: 100 ms at 4 ns.
`define ILSM_FLASH_NS       100000000
`define ILSM_CLK_NS         4
`define ILSM_FLASH_CYC      (`ILSM_FLASH_NS / `ILSM_CLK_NS)

`endif

// ==== tb/ilsm_monitor_asserts.sv ====
/* Assertion checker for the input lock and sync monitor.
   Assumes it is bound to ilsm_monitor and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module ilsm_monitor_asserts
    import ilsm_pkg::*;
#(parameter int N = 3, parameter int SELW = 2, parameter int FLASH_CYC = 8) (
    input wire logic              ref_clk_i,                    // Clock.
    input wire logic              arst_n_i,                     // Reset.
    input wire logic [N-1:0]      rx_lock_i,                    // Lock pins.
    input wire logic [N-1:0]      rx_fclk_i,                    // Frame clocks.
    input wire logic              int_fclk_i,                   // Internal clock.
    input wire logic              follow_external_clock_mode_i, // Follow mode.
    input wire logic [SELW-1:0]   follow_sel_i,                 // Followed input.
    input wire logic [15:0]       play_buf_i,                   // Buffer size.
    input wire ilsm_sample_s      pass_in_i,                    // Sample in.
    input wire ilsm_sample_s      pass_out_o,                   // Sample out.
    input wire logic              work_tick_o,                  // Frame pulse.
    input wire logic [N-1:0]      input_sync_indicator_o,       // Indicators.
    input wire logic [2*N-1:0]    status_o,                     // Status.
    input wire logic [15:0]       play_depth_o,                 // Play depth.
    input wire logic [15:0]       rec_depth_o                   // Record depth.
);
    // ********
    // Flash watch: counts cycles in which no locked indicator toggles.
    // ********
    logic [N-1:0] nl, lk, sy, prev_r;
    int           cnt_r, cnt_nxt;
    always_comb begin
        for (int i = 0; i < N; i++) begin
            nl[i] = status_o[2*i+:2] == ILSM_NOLOCK;
            lk[i] = status_o[2*i+:2] == ILSM_LOCK;
            sy[i] = status_o[2*i+:2] == ILSM_SYNC;
        end
        cnt_nxt = (lk != '0 && ((input_sync_indicator_o ^ prev_r) & lk) == '0) ? cnt_r + 1 : 0;
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_r <= '0;
            cnt_r  <= 0;
        end else begin
            prev_r <= input_sync_indicator_o;
            cnt_r  <= cnt_nxt;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_int; $rose(int_fclk_i) && !follow_external_clock_mode_i; endsequence
    sequence s_ext;
        $rose(rx_fclk_i[1]) && rx_lock_i[1] && follow_external_clock_mode_i && follow_sel_i == 1;
    endsequence
    property p_rec; $past(arst_n_i) |-> rec_depth_o == $past(play_buf_i); endproperty
    a_rec: assert property (p_rec) else $error("record depth wrong");
    property p_play; $past(arst_n_i) |-> play_depth_o == $past(play_buf_i) + 16'h0040; endproperty
    a_play: assert property (p_play) else $error("playback depth wrong");
    property p_dark; (input_sync_indicator_o & nl) == '0; endproperty
    a_dark: assert property (p_dark) else $error("unlocked indicator lit");
    property p_lit; (input_sync_indicator_o & sy) == sy; endproperty
    a_lit: assert property (p_lit) else $error("synced indicator dark");
    property p_flash; cnt_r < FLASH_CYC + 2; endproperty
    a_flash: assert property (p_flash) else $error("locked indicator not flashing");
    property p_int; s_int |-> ##[1:4] (work_tick_o || follow_external_clock_mode_i); endproperty
    a_int: assert property (p_int) else $error("no tick from internal clock");
    property p_ext; s_ext |-> ##[1:4] (work_tick_o || !follow_external_clock_mode_i); endproperty
    a_ext: assert property (p_ext) else $error("no tick from followed input");
    property p_pass; $past(arst_n_i) && !$past(work_tick_o) |-> $stable(pass_out_o); endproperty
    a_pass: assert property (p_pass) else $error("sample moved off a tick");
endmodule // ilsm_monitor_asserts
bind ilsm_monitor ilsm_monitor_asserts #(.N(N), .SELW(SELW), .FLASH_CYC(FLASH_CYC))
    ilsm_monitor_asserts_inst (
        .ref_clk_i                    (ref_clk_i),
        .arst_n_i                     (arst_n_i),
        .rx_lock_i                    (rx_lock_i),
        .rx_fclk_i                    (rx_fclk_i),
        .int_fclk_i                   (int_fclk_i),
        .follow_external_clock_mode_i (follow_external_clock_mode_i),
        .follow_sel_i                 (follow_sel_i),
        .play_buf_i                   (play_buf_i),
        .pass_in_i                    (pass_in_i),
        .pass_out_o                   (pass_out_o),
        .work_tick_o                  (work_tick_o),
        .input_sync_indicator_o       (input_sync_indicator_o),
        .status_o                     (status_o),
        .play_depth_o                 (play_depth_o),
        .rec_depth_o                  (rec_depth_o)
    );
`default_nettype wire

// ==== tb/ilsm_src_model.sv ====
/* External digital source model: a lock pin and a recovered frame clock.
   Assumes en_i comes from the bench; the clock stands still while idle. */
`timescale 1ns/100ps
`default_nettype none
module ilsm_src_model #(parameter realtime HALF = 80.0, parameter realtime PHASE = 0.0) (
    input  wire logic en_i,   // Source connected.
    output var  logic lock_o, // Receiver lock.
    output var  logic fclk_o  // Frame clock.
);
    initial begin
        lock_o = 1'b0;
        fclk_o = 1'b0;
        forever begin
            wait (en_i);
            #PHASE lock_o = 1'b1;
            while (en_i) begin
                #HALF fclk_o = ~fclk_o;
            end
            lock_o = 1'b0;
            fclk_o = 1'b0;
        end
    end
endmodule // ilsm_src_model
`default_nettype wire

// ==== tb/testbench.sv ====
/* Self-checking bench for the input lock and sync monitor.
   Assumes the package, the checker and the source model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ilsm_pkg::*;
    logic         ref_clk_i, arst_n_i, int_fclk_i, work_tick_o, follow_external_clock_mode_i;
    logic [1:0]   follow_sel_i;
    logic [2:0]   en, input_sync_indicator_o;
    wire  [2:0]   rx_lock_i, rx_fclk_i;
    logic [5:0]   status_o;
    logic [15:0]  play_buf_i, play_depth_o, rec_depth_o;
    ilsm_sample_s pass_in_i, pass_out_o;
    int           failures, num_checks;
    ilsm_monitor #(.N(3), .SELW(2), .FLASH_CYC(8)) ilsm_monitor_inst (
        .ref_clk_i                    (ref_clk_i),
        .arst_n_i                     (arst_n_i),
        .rx_lock_i                    (rx_lock_i),
        .rx_fclk_i                    (rx_fclk_i),
        .int_fclk_i                   (int_fclk_i),
        .follow_external_clock_mode_i (follow_external_clock_mode_i),
        .follow_sel_i                 (follow_sel_i),
        .play_buf_i                   (play_buf_i),
        .pass_in_i                    (pass_in_i),
        .pass_out_o                   (pass_out_o),
        .work_tick_o                  (work_tick_o),
        .input_sync_indicator_o       (input_sync_indicator_o),
        .status_o                     (status_o),
        .play_depth_o                 (play_depth_o),
        .rec_depth_o                  (rec_depth_o)
    );
    ilsm_src_model #(.HALF(80.0), .PHASE(37.0)) s0 (
        .en_i(en[0]), .lock_o(rx_lock_i[0]), .fclk_o(rx_fclk_i[0]));
    ilsm_src_model #(.HALF(77.0)) s1 (
        .en_i(en[1]), .lock_o(rx_lock_i[1]), .fclk_o(rx_fclk_i[1]));
    ilsm_src_model #(.HALF(80.0)) s2 (
        .en_i(en[2]), .lock_o(rx_lock_i[2]), .fclk_o(rx_fclk_i[2]));
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // The internal generator runs free, out of phase with the block clock.
    initial begin
        int_fclk_i = 1'b0;
        #13;
        forever #80 int_fclk_i = ~int_fclk_i;
    end
    initial begin
        #200000;
        failures++;
        stop_test();
    end
    task automatic wt(int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_reset();
        chk("rst status", 0, status_o);
        chk("rst ind", 0, input_sync_indicator_o);
        $display("test reset done");
    endtask
    task automatic t_depth();
        logic [15:0] v[3] = '{16'h0000, 16'h0100, 16'hFFBF};
        foreach (v[i]) begin
            play_buf_i = v[i];
            wt(2);
            chk("play", v[i] + 16'h0040, play_depth_o);
            chk("rec", v[i], rec_depth_o);
        end
        $display("test depth done");
    endtask
    task automatic t_sync();
        int   tg = 0;
        int   bad = 0;
        logic p = 1'b0;
        en = 3'b011;
        wt(7800);
        chk("status", {ILSM_NOLOCK, ILSM_LOCK, ILSM_SYNC}, status_o);
        repeat (40) begin
            tg += int'(input_sync_indicator_o[1] !== p);
            p = input_sync_indicator_o[1];
            bad += int'(input_sync_indicator_o[0] !== 1'b1);
            bad += int'(input_sync_indicator_o[2] !== 1'b0);
            wt(1);
        end
        chk("steady", 0, bad);
        chk("flash", 1, tg > 2);
        $display("test sync done");
    endtask
    task automatic t_follow();
        follow_external_clock_mode_i = 1'b1;
        follow_sel_i = 2'h1;
        wt(7800);
        chk("follow", {ILSM_NOLOCK, ILSM_SYNC, ILSM_LOCK}, status_o);
        en[0] = 1'b0;
        wt(60);
        chk("unlock", ILSM_NOLOCK, status_o[1:0]);
        follow_external_clock_mode_i = 1'b0;
        $display("test follow done");
    endtask
    task automatic t_pass();
        for (int i = 0; i < 8; i++) begin
            while (work_tick_o !== 1'b1) wt(1);
            wt(1);
            if (i >= 4) chk("pass", {24'(i - 3), 24'(i + 5)}, pass_out_o);
            pass_in_i = '{24'(i), 24'(i + 8)};
        end
        $display("test pass done");
    endtask
    initial begin
        arst_n_i = 1'b0;
        follow_external_clock_mode_i = 1'b0;
        follow_sel_i = 2'h0;
        play_buf_i = 16'h0000;
        pass_in_i = '0;
        en = 3'b000;
        wt(12);
        t_reset();
        arst_n_i = 1'b1;
        t_depth();
        t_sync();
        t_follow();
        t_pass();
        stop_test();
    end
endmodule // testbench
`default_nettype wire
